// [sbtc_pkg.sv]
package sbtc_pkg;
    // bus geometry: word index is ADR_I[11:2]
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam int          IDX_W         = 10;

    // register word indexes; byte address is four times the index
    localparam logic [9:0]  IDX_FLAG      = 10'h00C;
    localparam logic [9:0]  IDX_ENABLE    = 10'h08C;
    localparam logic [9:0]  IDX_LOW       = 10'h00E;
    localparam logic [9:0]  IDX_HIGH      = 10'h00F;
    localparam logic [9:0]  IDX_CONTROL   = 10'h010;
    localparam logic [9:0]  IDX_PORT      = 10'h011;

    // timer_control fields
    localparam int          CTL_RUN       = 0;
    localparam int          CTL_SRC       = 1;
    localparam int          CTL_BYPASS    = 2;
    localparam int          CTL_OSC       = 3;
    localparam int          CTL_PS_LO     = 4;
    localparam int          CTL_PS_HI     = 5;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  CONTROL_MASK  = 8'h3F;

    // flag and enable registers
    localparam int          FLAG_BIT      = 0;
    localparam int          ENABLE_BIT    = 0;

    // port register: output latch in [1:0], direction in [5:4], 1 = input
    localparam int          PORT_OUT_LO   = 0;
    localparam int          PORT_DIR_LO   = 4;
    localparam logic [7:0]  PORT_RESET    = 8'h30;
    localparam logic [7:0]  PORT_MASK     = 8'h33;

    // count limits
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;

    // reference clock is the oscillator; one instruction cycle is four clocks
    localparam int          REF_CLK_MHZ   = 250;
    localparam int          OSC_PER_INSTR = 4;
    localparam logic [1:0]  INSTR_LAST    = 2'(OSC_PER_INSTR - 1);

    // prescaler width, in bits, of the divide counter
    localparam int          PS_W          = 3;

    typedef enum logic [1:0] {
        ARM_IDLE,
        ARM_WAIT_FALL,
        ARM_LIVE
    } sbtc_arm_type;
endpackage : sbtc_pkg

// [sbtc_prescale.sv]
`timescale 1ns/1ns
module sbtc_prescale (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // input events and control
    input  wire logic       tick,
    input  wire logic       clear,
    input  wire logic [1:0] ratio,
    // one pulse per 1, 2, 4 or 8 events, as ratio selects
    output logic            carry
);
    logic [sbtc_pkg::PS_W-1:0] count;
    logic [sbtc_pkg::PS_W-1:0] next_count;
    logic [sbtc_pkg::PS_W-1:0] mask;

    always_comb begin
        unique case (ratio)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            2'h3: mask = 3'h7;
        endcase
        carry      = tick & ((count & mask) == mask);
        next_count = count;
        if (clear) begin
            next_count = 3'h0;
        end else if (tick) begin
            next_count = carry ? 3'h0 : 3'(count + 3'h1);
        end
    end

    // synchronous stand-in for the ripple chain, so no divided clocks exist
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 3'h0;
        end else begin
            count <= next_count;
        end
    end
endmodule : sbtc_prescale

// [sbtc_sync2.sv]
`timescale 1ns/1ns
module sbtc_sync2 (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // toggle from the prescaler side
    input  wire logic level_in,
    // one-cycle pulse per toggle
    output logic      changed
);
    logic meta;
    logic stable;
    logic last;
    logic next_meta;
    logic next_stable;
    logic next_last;

    always_comb begin
        next_meta   = level_in;
        next_stable = meta;
        next_last   = stable;
        changed     = stable ^ last;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            last   <= 1'b0;
        end else begin
            meta   <= next_meta;
            stable <= next_stable;
            last   <= next_last;
        end
    end
endmodule : sbtc_sync2

// [sbtc_top.sv]
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ns
//
// Overview of operation
// - sixteen-bit count, two bytes, wraps FFFF to 0000
// - overflow latches flag; request only when enabled
// - source bit: instruction cycle or external rising edge
// - run bit gates counting; stop holds count
// - capture/compare units may reset the count
// - oscillator on: pins inputs, read zero
// - prescale bits select 1, 2, 4, 8
// - oscillator enable bit powers the oscillator
// - bypass bit skips synchroniser in external mode
// - falling edge needed before first counted rise
// - oscillator enable picks which pin counts
// - prescaler first, then synchroniser
// - synchronised mode stops counting during sleep
// - unsynchronised mode counts and wakes in sleep
// - count byte write clears the prescaler
// - compare reset sets no flag; write wins
// - reset clears control; count keeps value
module sbtc_top (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET_N,
    // wishbone slave
    input  wire logic [11:0] ADR_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    input  wire logic        WE_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        STB_I,
    input  wire logic        CYC_I,
    output logic             ACK_O,
    // system
    input  wire logic        SLEEP_MODE,
    input  wire logic        CC_RESET_A,
    input  wire logic        CC_RESET_B,
    // pins: bit 0 external clock / oscillator output, bit 1 oscillator input
    input  wire logic [1:0]  PIN_IN,
    output logic      [1:0]  PIN_OUT,
    output logic      [1:0]  PIN_OE,
    output logic             OSC_POWER,
    // requests
    output logic             IRQ,
    output logic             WAKE_REQ
);
    logic                  rst_meta;
    logic                  rst_n_int;
    logic [7:0]            control;
    logic [7:0]            next_control;
    logic [7:0]            port;
    logic [7:0]            next_port;
    logic                  flag;
    logic                  next_flag;
    logic                  enable;
    logic                  next_enable;
    logic [15:0]           count;
    logic [15:0]           next_count;
    logic [1:0]            div;
    logic [1:0]            next_div;
    logic                  pin_prev;
    logic                  next_pin_prev;
    logic                  ps_toggle;
    logic                  next_ps_toggle;
    sbtc_pkg::sbtc_arm_type arm;
    sbtc_pkg::sbtc_arm_type next_arm;
    logic [31:0]           next_dat;
    logic                  next_ack;
    logic [1:0]            next_pin_out;
    logic [1:0]            next_pin_oe;
    logic                  bus_req;
    logic                  wr;
    logic [9:0]            idx;
    logic                  wr_low;
    logic                  wr_high;
    logic                  wr_count;
    logic                  cc_reset;
    logic                  run;
    logic                  src_ext;
    logic                  bypass;
    logic                  osc_en;
    logic [1:0]            ratio;
    logic                  tick;
    logic                  pin_sel;
    logic                  ext_live;
    logic                  ext_rise;
    logic                  ps_in;
    logic                  carry;
    logic                  changed;
    logic                  sync_inc;
    logic                  direct_inc;
    logic                  inc;
    logic                  ovf;
    logic [7:0]            rd_byte;
    logic [7:0]            pin_view;

    // reset release through two flops
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta  <= 1'b0;
            rst_n_int <= 1'b0;
        end else begin
            rst_meta  <= 1'b1;
            rst_n_int <= rst_meta;
        end
    end

    // decode
    always_comb begin
        bus_req  = CYC_I & STB_I;
        idx      = ADR_I[11:2];
        // writes land on the edge where ack is seen high
        wr       = bus_req & ACK_O & WE_I & SEL_I[0];
        wr_low   = wr & (idx == sbtc_pkg::IDX_LOW);
        wr_high  = wr & (idx == sbtc_pkg::IDX_HIGH);
        wr_count = wr_low | wr_high;
        cc_reset = CC_RESET_A | CC_RESET_B;
        run      = control[sbtc_pkg::CTL_RUN];
        src_ext  = control[sbtc_pkg::CTL_SRC];
        bypass   = control[sbtc_pkg::CTL_BYPASS];
        osc_en   = control[sbtc_pkg::CTL_OSC];
        ratio    = control[sbtc_pkg::CTL_PS_HI:sbtc_pkg::CTL_PS_LO];
    end

    // clock sources and arming
    always_comb begin
        tick          = (div == sbtc_pkg::INSTR_LAST);
        next_div      = 2'(div + 2'h1);
        pin_sel       = osc_en ? PIN_IN[1] : PIN_IN[0];
        next_pin_prev = pin_sel;
        ext_live      = run & src_ext;
        next_arm      = arm;
        unique case (arm)
            sbtc_pkg::ARM_IDLE: begin
                if (ext_live) begin
                    next_arm = sbtc_pkg::ARM_WAIT_FALL;
                end
            end
            sbtc_pkg::ARM_WAIT_FALL: begin
                if (!ext_live) begin
                    next_arm = sbtc_pkg::ARM_IDLE;
                end else if (pin_prev && !pin_sel) begin
                    next_arm = sbtc_pkg::ARM_LIVE;
                end
            end
            sbtc_pkg::ARM_LIVE: begin
                if (!ext_live) begin
                    next_arm = sbtc_pkg::ARM_IDLE;
                end
            end
            default: begin
                next_arm = sbtc_pkg::ARM_IDLE;
            end
        endcase
        // run gate here too: arm leaves live one cycle after run drops
        ext_rise = (arm == sbtc_pkg::ARM_LIVE) & ext_live & !pin_prev & pin_sel;
        // instruction clock halts in sleep; external edges keep reaching the prescaler
        ps_in    = src_ext ? ext_rise : (run & tick & !SLEEP_MODE);
    end

    always_ff @(posedge REF_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            div      <= 2'h0;
            pin_prev <= 1'b0;
            arm      <= sbtc_pkg::ARM_IDLE;
        end else begin
            div      <= next_div;
            pin_prev <= next_pin_prev;
            arm      <= next_arm;
        end
    end

    sbtc_prescale u_prescale (
        .clk   (REF_CLK),
        .rst_n (rst_n_int),
        .tick  (ps_in),
        .clear (wr_count),
        .ratio (ratio),
        .carry (carry)
    );

    // a toggle crosses safely where a one-cycle carry could be missed
    always_comb begin
        next_ps_toggle = ps_toggle ^ (carry & src_ext & !bypass);
    end

    always_ff @(posedge REF_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            ps_toggle <= 1'b0;
        end else begin
            ps_toggle <= next_ps_toggle;
        end
    end

    sbtc_sync2 u_sync (
        .clk      (REF_CLK),
        .rst_n    (rst_n_int),
        .level_in (ps_toggle),
        .changed  (changed)
    );

    // increment and count
    always_comb begin
        sync_inc   = changed & run & src_ext & !bypass & !SLEEP_MODE;
        direct_inc = carry & (!src_ext | bypass);
        inc        = sync_inc | direct_inc;
        ovf        = inc & !wr_count & !cc_reset & (count == sbtc_pkg::COUNT_MAX);
        next_count = count;
        if (wr_count) begin
            if (wr_low) begin
                next_count[7:0] = DAT_I[7:0];
            end
            if (wr_high) begin
                next_count[15:8] = DAT_I[7:0];
            end
        end else if (cc_reset) begin
            next_count = sbtc_pkg::COUNT_ZERO;
        end else if (inc) begin
            next_count = 16'(count + 16'h0001);
        end
    end

    // count survives every reset
    always_ff @(posedge REF_CLK) begin
        count <= next_count;
    end

    // registers
    always_comb begin
        next_control = control;
        next_port    = port;
        next_enable  = enable;
        next_flag    = flag;
        if (wr && idx == sbtc_pkg::IDX_CONTROL) begin
            next_control = DAT_I[7:0] & sbtc_pkg::CONTROL_MASK;
        end
        if (wr && idx == sbtc_pkg::IDX_PORT) begin
            next_port = DAT_I[7:0] & sbtc_pkg::PORT_MASK;
        end
        if (wr && idx == sbtc_pkg::IDX_ENABLE) begin
            next_enable = DAT_I[sbtc_pkg::ENABLE_BIT];
        end
        if (wr && idx == sbtc_pkg::IDX_FLAG) begin
            next_flag = DAT_I[sbtc_pkg::FLAG_BIT];
        end
        if (ovf) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            control <= sbtc_pkg::CONTROL_RESET;
            port    <= sbtc_pkg::PORT_RESET;
            enable  <= 1'b0;
            flag    <= 1'b0;
        end else begin
            control <= next_control;
            port    <= next_port;
            enable  <= next_enable;
            flag    <= next_flag;
        end
    end

    // bus answer and outputs
    always_comb begin
        pin_view = {2'h0, port[sbtc_pkg::PORT_DIR_LO +: 2], 2'h0, osc_en ? 2'h0 : PIN_IN};
        unique case (idx)
            sbtc_pkg::IDX_FLAG:    rd_byte = {7'h00, flag};
            sbtc_pkg::IDX_ENABLE:  rd_byte = {7'h00, enable};
            sbtc_pkg::IDX_LOW:     rd_byte = count[7:0];
            sbtc_pkg::IDX_HIGH:    rd_byte = count[15:8];
            sbtc_pkg::IDX_CONTROL: rd_byte = control;
            sbtc_pkg::IDX_PORT:    rd_byte = pin_view;
            default:               rd_byte = 8'h00;
        endcase
        next_ack     = bus_req & !ACK_O;
        next_dat     = next_ack ? {24'h000000, rd_byte} : DAT_O;
        next_pin_out = next_port[sbtc_pkg::PORT_OUT_LO +: 2];
        // oscillator owns both pins, so direction bits lose their say
        next_pin_oe  = next_control[sbtc_pkg::CTL_OSC] ? 2'h0 : ~next_port[sbtc_pkg::PORT_DIR_LO +: 2];
    end

    always_ff @(posedge REF_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            DAT_O     <= 32'h00000000;
            ACK_O     <= 1'b0;
            PIN_OUT   <= 2'h0;
            PIN_OE    <= 2'h0;
            OSC_POWER <= 1'b0;
            IRQ       <= 1'b0;
            WAKE_REQ  <= 1'b0;
        end else begin
            DAT_O     <= next_dat;
            ACK_O     <= next_ack;
            PIN_OUT   <= next_pin_out;
            PIN_OE    <= next_pin_oe;
            OSC_POWER <= next_control[sbtc_pkg::CTL_OSC];
            IRQ       <= next_flag & next_enable;
            WAKE_REQ  <= next_flag & next_enable & SLEEP_MODE;
        end
    end

    // checking helper: prescaler inputs since last carry
    logic [3:0] chk_events;
    logic [1:0] chk_ratio;
    // ratio change leaves a partial prescale count; count bytes power up unknown
    logic       chk_ps_valid;
    logic [1:0] chk_loaded;
    always_ff @(posedge REF_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            chk_events   <= 4'h0;
            chk_ratio    <= 2'h0;
            chk_ps_valid <= 1'b0;
            chk_loaded   <= 2'h0;
        end else begin
            chk_ratio    <= ratio;
            chk_events   <= (carry || wr_count) ? 4'h0 : 4'(chk_events + {3'h0, ps_in});
            chk_ps_valid <= carry || wr_count || (chk_ps_valid && ratio == chk_ratio);
            chk_loaded   <= chk_loaded | {wr_high, wr_low};
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!rst_n_int);

    chk_wrap_to_zero: assert property (ovf |=> count == sbtc_pkg::COUNT_ZERO)
        else $error("count did not wrap to zero");
    chk_flag_latch: assert property (ovf |=> flag && IRQ == enable)
        else $error("overflow flag not latched");
    chk_irq_gated: assert property (IRQ |-> flag && enable)
        else $error("interrupt without flag and enable");
    chk_internal_tick: assert property ((inc && !src_ext) |-> tick && run)
        else $error("internal count off instruction tick");
    chk_stop_holds: assert property ((&chk_loaded && !run && !wr_count && !cc_reset) |=> count == $past(count))
        else $error("stopped timer changed count");
    chk_cc_clears: assert property ((cc_reset && !wr_count) |=> count == sbtc_pkg::COUNT_ZERO && !$rose(flag))
        else $error("compare reset misbehaved");
    chk_write_beats_cc: assert property ((wr_high && cc_reset) |=> count[15:8] == $past(DAT_I[7:0]))
        else $error("compare reset beat a write");
    chk_osc_pins_in: assert property (control[sbtc_pkg::CTL_OSC] |-> PIN_OE == 2'h0 && OSC_POWER)
        else $error("pins driven with oscillator on");
    chk_prescale_ratio: assert property ((carry && chk_ps_valid && chk_ratio == ratio) |->
        chk_events == 4'((4'h1 << ratio) - 4'h1))
        else $error("prescale ratio wrong");
    chk_bypass_path: assert property ((carry && src_ext && bypass) |-> inc)
        else $error("bypassed carry did not count");
    chk_fall_first: assert property ((arm != sbtc_pkg::ARM_LIVE) |-> !ext_rise)
        else $error("rise counted before falling edge");
    chk_sync_latency: assert property ((carry && src_ext && !bypass) |-> ##3 changed)
        else $error("synchroniser latency wrong");
    chk_sleep_sync_stop: assert property ((SLEEP_MODE && src_ext && !bypass) |-> !inc)
        else $error("synchronised count moved in sleep");
    chk_sync_one_pulse: assert property (sync_inc |=> !changed)
        else $error("synchroniser pulse too long");
    chk_ps_clear: assert property (wr_count |=> chk_events == 4'h0)
        else $error("prescaler not cleared by write");

    cov_overflow: cover property (ovf ##1 IRQ);
    cov_cc_reset: cover property (cc_reset && run);
    cov_sync_inc: cover property (sync_inc);
    cov_wake: cover property (WAKE_REQ);
endmodule : sbtc_top

// [sbtc_clk_source.sv]
`timescale 1ns/1ns
module sbtc_clk_source (
    // clock
    input  wire logic       clk,
    // pin levels toward the timer
    output logic      [1:0] pin
);
    initial begin
        pin = 2'h0;
    end
    // rests low between frames, so only rises after a fall count
    task automatic pulses(input int s, input int n, input int half);
        for (int i = 0; i < n; i++) begin
            pin[s] <= 1'b1;
            repeat (half) @(posedge clk);
            pin[s] <= 1'b0;
            repeat (half) @(posedge clk);
        end
    endtask : pulses
    task automatic hold(input logic [1:0] lv);
        pin <= lv;
    endtask : hold
endmodule : sbtc_clk_source

// [tb_sixteen_bit_timer_counter.sv]
`timescale 1ns/1ns
module tb_sixteen_bit_timer_counter;
    localparam logic [9:0] a_ctl  = sbtc_pkg::IDX_CONTROL;
    localparam logic [9:0] a_lo   = sbtc_pkg::IDX_LOW;
    localparam logic [9:0] a_hi   = sbtc_pkg::IDX_HIGH;
    localparam logic [9:0] a_flg  = sbtc_pkg::IDX_FLAG;
    localparam logic [9:0] a_en   = sbtc_pkg::IDX_ENABLE;
    localparam logic [9:0] a_port = sbtc_pkg::IDX_PORT;
    logic        clk, rst_n, we, stb, cyc, ack, sleep, cc_a, cc_b;
    logic        osc_power, irq, wake;
    logic [11:0] adr;
    logic [31:0] wdat, dat_o, rd;
    logic [3:0]  sel;
    logic [1:0]  src_pin, pin_out, pin_oe, pin_in;
    logic [15:0] v, w;
    int          num_errors, check_count, cyc_now, ack_cyc, t0, n;

    // a pin follows the timer while it drives, else the source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src_pin);

    sbtc_top dut (
        .REF_CLK(clk), .RESET_N(rst_n), .ADR_I(adr), .DAT_I(wdat),
        .DAT_O(dat_o), .WE_I(we), .SEL_I(sel), .STB_I(stb), .CYC_I(cyc),
        .ACK_O(ack), .SLEEP_MODE(sleep), .CC_RESET_A(cc_a),
        .CC_RESET_B(cc_b), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .OSC_POWER(osc_power), .IRQ(irq), .WAKE_REQ(wake)
    );
    sbtc_clk_source src (
        .clk(clk),
        .pin(src_pin)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc_now <= cyc_now + 1;

    function automatic logic [15:0] int_exp(input logic [15:0] b, input int t, input int c);
        return b + 16'(t / (4 << c));
    endfunction : int_exp
    function automatic logic [15:0] ext_exp(input logic [15:0] b, input int p, input int c);
        return b + 16'((p - 1) >> c);
    endfunction : ext_exp

    task automatic give_verdict;
        $display("%0d checks, %0d wrong", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    task automatic wb(input logic wr, input logic [9:0] idx, input logic [7:0] d, input logic drop = 1'b0);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
        rd = dat_o;
        ack_cyc = cyc_now;
        // compare reset released at the edge where the write lands, so both meet on that edge
        if (drop) cc_b <= 1'b0;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // free-running phase of the instruction tick leaves one count of slack
    task automatic chk_near(input string nm, input logic [15:0] e, input logic [15:0] g);
        logic [15:0] d;
        d = g - e;
        check_count++;
        if (^g === 1'bx || (d != 16'h0 && d != 16'h1 && d != 16'hFFFF)) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_near

    task automatic get_cnt(output logic [15:0] c);
        wb(0, a_lo, 8'h00);
        c[7:0] = rd[7:0];
        wb(0, a_hi, 8'h00);
        c[15:8] = rd[7:0];
    endtask : get_cnt
    task automatic set_cnt(input logic [15:0] c);
        wb(1, a_lo, c[7:0]);
        wb(1, a_hi, c[15:8]);
    endtask : set_cnt
    task automatic done_test(input string nm);
        $display("test %s ends: %0d checks, %0d wrong", nm, check_count, num_errors);
    endtask : done_test

    initial begin
        {rst_n, we, stb, cyc, sleep, cc_a, cc_b} = 7'h00;
        adr = 12'h000;
        wdat = 32'h0;
        sel = 4'hF;
        {num_errors, check_count, cyc_now} = {32'h0, 32'h0, 32'h0};
        void'($urandom(72664));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        wb(0, a_ctl, 8'h00);
        chk("control", 32'h0, rd);
        wb(0, a_port, 8'h00);
        chk("port", 32'h30, rd);
        wb(0, 10'h3FF, 8'h00);
        chk("unmapped", 32'h0, rd);
        done_test("reset");
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
            set_cnt(v);
            get_cnt(w);
            chk("count", {16'h0, v}, {16'h0, w});
        end
        for (int c = 0; c < 4; c++) begin
            v = 16'($urandom);
            set_cnt(v);
            wb(1, a_ctl, {2'b00, 2'(c), 1'b0, 1'(c), 2'b01});
            t0 = ack_cyc;
            repeat (40 + $urandom % 40) @(posedge clk);
            wb(1, a_ctl, 8'h00);
            get_cnt(w);
            chk_near("timer", int_exp(v, ack_cyc - t0, c), w);
            repeat (20) @(posedge clk);
            get_cnt(v);
            chk("held", {16'h0, w}, {16'h0, v});
        end
        done_test("prescale");
        wb(1, a_en, 8'h01);
        set_cnt(16'hFFFE);
        wb(1, a_ctl, 8'h01);
        for (n = 0; irq !== 1'b1 && n < 100; n++) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        if (irq !== 1'b1) give_verdict();
        wb(1, a_ctl, 8'h00);
        get_cnt(w);
        chk("wrap", 32'h0, {24'h0, w[15:8]});
        wb(1, a_en, 8'h00);
        repeat (2) @(posedge clk);
        chk("masked", 32'h0, {31'h0, irq});
        wb(0, a_flg, 8'h00);
        chk("flag", 32'h1, rd);
        wb(1, a_flg, 8'h00);
        done_test("overflow");
        for (int u = 0; u < 2; u++) begin
            set_cnt(16'hFFF0);
            wb(1, a_ctl, 8'h01);
            cc_a <= (u == 0);
            cc_b <= (u == 1);
            @(posedge clk);
            {cc_a, cc_b} <= 2'b00;
            wb(1, a_ctl, 8'h00);
            get_cnt(w);
            chk("cleared", 32'h1, {31'h0, w < 16'h0010});
        end
        wb(0, a_flg, 8'h00);
        chk("no flag", 32'h0, rd);
        cc_b <= 1'b1;
        wb(1, a_hi, 8'h5A, 1'b1);
        get_cnt(w);
        chk("write wins", 32'h5A00, {16'h0, w});
        done_test("compare reset");
        for (int k = 0; k < 4; k++) begin
            wb(1, a_ctl, 8'h00);
            v = 16'($urandom);
            set_cnt(v);
            n = (1 << (3 - k)) * (2 + $urandom % 3) + 1;
            wb(1, a_ctl, {2'b00, 2'(3 - k), 1'(k >> 1), 1'(k), 2'b11});
            src.pulses(k >> 1, n, 2 + $urandom % 3);
            src.pulses(1 - (k >> 1), 3, 2);
            repeat (8) @(posedge clk);
            chk("osc power", {31'h0, 1'(k >> 1)}, {31'h0, osc_power});
            get_cnt(w);
            chk("edges", {16'h0, ext_exp(v, n, 3 - k)}, {16'h0, w});
        end
        done_test("external");
        wb(1, a_en, 8'h01);
        // a random start near the top may have wrapped above
        wb(1, a_flg, 8'h00);
        for (int b = 0; b < 2; b++) begin
            wb(1, a_ctl, 8'h00);
            set_cnt(16'hFFFE);
            wb(1, a_ctl, {5'h00, 1'(b), 2'b11});
            sleep <= 1'b1;
            src.pulses(0, 4, 3);
            repeat (8) @(posedge clk);
            chk("wake", {31'h0, 1'(b)}, {31'h0, wake});
            sleep <= 1'b0;
            get_cnt(w);
            chk("asleep", {16'h0, b ? 16'h0001 : 16'hFFFE}, {16'h0, w});
        end
        wb(1, a_flg, 8'h00);
        done_test("sleep");
        wb(1, a_ctl, 8'h00);
        wb(1, a_port, 8'h01);
        repeat (4) @(posedge clk);
        chk("drive", 32'h3, {30'h0, pin_oe});
        chk("pin out", 32'h1, {30'h0, pin_out});
        wb(0, a_port, 8'h00);
        chk("port out", 32'h01, rd);
        src.hold(2'b11);
        wb(1, a_ctl, 8'h08);
        repeat (4) @(posedge clk);
        chk("pins free", 32'h0, {30'h0, pin_oe});
        wb(0, a_port, 8'h00);
        chk("port osc", 32'h00, rd);
        src.hold(2'b00);
        done_test("pins");
        give_verdict();
    end
endmodule : tb_sixteen_bit_timer_counter
